// ==== verilog/protect_pkg.sv ====
// Purpose: shared constants and types of the motor current supervisor
// Assumes: currents are given in percent of rated motor current
// Notes: delays and the start timeout are counted in whole seconds
package protect_pkg;

    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int LEVEL_W = 10;
    localparam int DELAY_W = 6;
    localparam int ADDR_W = 6;
    localparam int NUM_TIMERS = 4;
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SECOND_CYCLES = SECOND_NS / CLOCK_PERIOD_NS;

    // Timer slots
    localparam int T_START = 0;
    localparam int T_OC2 = 1;
    localparam int T_NS1 = 2;
    localparam int T_NS2 = 3;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_ENABLE = 6'h00;
    localparam logic [5:0] OFS_START_TIMEOUT = 6'h04;
    localparam logic [5:0] OFS_OC1_LEVEL = 6'h08;
    localparam logic [5:0] OFS_OC2_LEVEL = 6'h0c;
    localparam logic [5:0] OFS_OC2_DELAY = 6'h10;
    localparam logic [5:0] OFS_NS1_LEVEL = 6'h14;
    localparam logic [5:0] OFS_NS1_DELAY = 6'h18;
    localparam logic [5:0] OFS_NS2_LEVEL = 6'h1c;
    localparam logic [5:0] OFS_NS2_DELAY = 6'h20;
    localparam logic [5:0] OFS_TRIP_STATUS = 6'h24;
    localparam logic [5:0] OFS_FAULT_RESET = 6'h28;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h2c;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h30;
    localparam logic [5:0] OFS_IRQ_CLEAR = 6'h34;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [4:0] RST_ENABLE = 5'h1f;
    localparam logic [5:0] RST_START_TIMEOUT = 6'h32;
    localparam logic [9:0] RST_OC1_LEVEL = 10'h1c2;
    localparam logic [9:0] RST_OC2_LEVEL = 10'h078;
    localparam logic [5:0] RST_OC2_DELAY = 6'h03;
    localparam logic [9:0] RST_NS1_LEVEL = 10'h032;
    localparam logic [5:0] RST_NS1_DELAY = 6'h01;
    localparam logic [9:0] RST_NS2_LEVEL = 10'h00f;
    localparam logic [5:0] RST_NS2_DELAY = 6'h0a;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        standby, ready, soft_start, direct_start, running, soft_stop
    } op_state_t;

    typedef struct packed {
        logic [LEVEL_W-1:0] ia;
        logic [LEVEL_W-1:0] ib;
        logic [LEVEL_W-1:0] ic;
        logic [LEVEL_W-1:0] ineg;
    } currents_t;

    typedef struct packed {
        logic ns2;
        logic ns1;
        logic oc2;
        logic oc1;
        logic start_timeout;
    } trip_t;

endpackage

// ==== verilog/second_tick.sv ====
// Purpose: one-cycle pulse once per second, the timebase of all delays
// Assumes: CYCLES is the number of clock cycles in one second
// Notes: free running; delays therefore carry up to one second of slack
`timescale 1ns/1ps
`default_nettype none
module second_tick
#(
    parameter int unsigned CYCLES = 20_000_000
)
(
    input wire logic clock,
    input wire logic rst,
    output logic tick
);
    localparam int W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cnt <= '0;
        else if (cnt == LAST)
            cnt <= '0;
        else
            cnt <= cnt + 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tick <= 1'b0;
        else
            tick <= (cnt == LAST);
    end
endmodule
`default_nettype wire

// ==== verilog/delay_timer.sv ====
// Purpose: seconds counter that runs while its condition holds
// Assumes: tick is a one-cycle pulse per second
// Notes: expires once more than delay seconds have been counted
`timescale 1ns/1ps
`default_nettype none
module delay_timer
#(
    parameter int W = 6
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    input wire logic cond,
    input wire logic [W-1:0] delay,
    output logic [W-1:0] count,
    output logic expired
);
    // Saturating, so a long excursion cannot wrap and release a trip
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count <= '0;
        else if (!cond)
            count <= '0;
        else if (tick && count != '1)
            count <= count + 1'b1;
    end

    assign expired = cond && (count > delay);
endmodule
`default_nettype wire

// ==== verilog/current_supervisor.sv ====
// Purpose: current and start-time protection for a motor soft starter
// Assumes: currents and state are synchronous; registers on a plain port
// Notes: trips latch until a fault reset from pin or register
// Notes on behaviour
// - Start trips when start time runs past the start timeout setting.
// - A start timeout trip forces shutdown and a failure report.
// - Each protection acts only while its enable bit is set.
// - Overcurrent stage one trips at once when any phase exceeds it.
// - Overcurrent stage one is live in every operating state.
// - In a direct start its level doubles until start time elapses.
// - Overcurrent stage two is live in standby, ready and running only.
// - Stage two trips after a full delay above level, else it releases.
// - Negative-sequence stage one is live in every operating state.
// - Its level is four times higher during starts and soft stop.
// - Negative-sequence stage one trips after a full delay above level.
// - Negative-sequence stage two trips after its delay above level.
// - Negative-sequence stage two is blocked in starts and soft stop.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module current_supervisor
#(
    parameter int unsigned TICK_CYCLES = protect_pkg::SECOND_CYCLES
)
(
    input wire logic clock,
    input wire logic rst,
    input wire protect_pkg::op_state_t op_state,
    input wire protect_pkg::currents_t meas,
    input wire logic fault_reset,
    input wire logic [protect_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output protect_pkg::trip_t trip,
    output logic shutdown,
    output logic failure_report,
    output logic irq
);
    import protect_pkg::*;

    // ----------------------------------------------------------------
    // Settings
    // ----------------------------------------------------------------
    trip_t enable;
    logic [DELAY_W-1:0] start_timeout;
    logic [LEVEL_W-1:0] oc1_level;
    logic [LEVEL_W-1:0] oc2_level;
    logic [DELAY_W-1:0] oc2_delay;
    logic [LEVEL_W-1:0] ns1_level;
    logic [DELAY_W-1:0] ns1_delay;
    logic [LEVEL_W-1:0] ns2_level;
    logic [DELAY_W-1:0] ns2_delay;
    trip_t irq_status;
    trip_t irq_enable;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            enable <= RST_ENABLE;
            start_timeout <= RST_START_TIMEOUT;
            oc1_level <= RST_OC1_LEVEL;
            oc2_level <= RST_OC2_LEVEL;
            oc2_delay <= RST_OC2_DELAY;
            ns1_level <= RST_NS1_LEVEL;
            ns1_delay <= RST_NS1_DELAY;
            ns2_level <= RST_NS2_LEVEL;
            ns2_delay <= RST_NS2_DELAY;
            irq_enable <= '0;
        end
        else if (wr)
        begin
            case (addr)
                OFS_ENABLE: enable <= wdata[4:0];
                OFS_START_TIMEOUT: start_timeout <= wdata[DELAY_W-1:0];
                OFS_OC1_LEVEL: oc1_level <= wdata[LEVEL_W-1:0];
                OFS_OC2_LEVEL: oc2_level <= wdata[LEVEL_W-1:0];
                OFS_OC2_DELAY: oc2_delay <= wdata[DELAY_W-1:0];
                OFS_NS1_LEVEL: ns1_level <= wdata[LEVEL_W-1:0];
                OFS_NS1_DELAY: ns1_delay <= wdata[DELAY_W-1:0];
                OFS_NS2_LEVEL: ns2_level <= wdata[LEVEL_W-1:0];
                OFS_NS2_DELAY: ns2_delay <= wdata[DELAY_W-1:0];
                OFS_IRQ_ENABLE: irq_enable <= wdata[4:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Operating state decode and thresholds
    // ----------------------------------------------------------------
    logic tick;
    logic starting;
    logic quiet_state;
    logic [LEVEL_W:0] oc1_limit;
    logic [LEVEL_W+1:0] ns1_limit;
    logic oc1_over;
    logic oc2_over;
    logic ns1_over;
    logic ns2_over;
    logic [NUM_TIMERS-1:0] tcond;
    logic [NUM_TIMERS-1:0] texp;
    logic [DELAY_W-1:0] tdelay [NUM_TIMERS];
    logic [DELAY_W-1:0] tcount [NUM_TIMERS];

    second_tick #(.CYCLES(TICK_CYCLES)) u_tick
    (
        .clock(clock),
        .rst(rst),
        .tick(tick)
    );

    assign starting = (op_state == soft_start) || (op_state == direct_start);
    assign quiet_state = (op_state == standby) || (op_state == ready)
        || (op_state == running);

    // Doubled only until the start time has run out
    assign oc1_limit = (op_state == direct_start && !texp[T_START])
        ? {oc1_level, 1'b0} : {1'b0, oc1_level};
    assign ns1_limit = (starting || op_state == soft_stop)
        ? {ns1_level, 2'b00} : {2'b00, ns1_level};

    assign oc1_over = ({1'b0, meas.ia} > oc1_limit)
        || ({1'b0, meas.ib} > oc1_limit)
        || ({1'b0, meas.ic} > oc1_limit);
    assign oc2_over = (meas.ia > oc2_level) || (meas.ib > oc2_level)
        || (meas.ic > oc2_level);
    assign ns1_over = ({2'b00, meas.ineg} > ns1_limit);
    assign ns2_over = (meas.ineg > ns2_level);

    // ----------------------------------------------------------------
    // Delay timers
    // ----------------------------------------------------------------
    // The start timer measures start time even with the trip disabled,
    // because the doubled overcurrent level also ends on it.
    assign tcond[T_START] = starting;
    assign tcond[T_OC2] = enable.oc2 && quiet_state
        && oc2_over;
    assign tcond[T_NS1] = enable.ns1 && ns1_over;
    assign tcond[T_NS2] = enable.ns2 && quiet_state
        && ns2_over;
    assign tdelay[T_START] = start_timeout;
    assign tdelay[T_OC2] = oc2_delay;
    assign tdelay[T_NS1] = ns1_delay;
    assign tdelay[T_NS2] = ns2_delay;

    for (genvar i = 0; i < NUM_TIMERS; i++)
    begin : g_timer
        delay_timer #(.W(DELAY_W)) u_timer
        (
            .clock(clock),
            .rst(rst),
            .tick(tick),
            .cond(tcond[i]),
            .delay(tdelay[i]),
            .count(tcount[i]),
            .expired(texp[i])
        );
    end

    // ----------------------------------------------------------------
    // Trip latches
    // ----------------------------------------------------------------
    trip_t trip_set;
    trip_t next_trip;
    logic fault_clear;

    assign trip_set.start_timeout = enable.start_timeout
        && texp[T_START];
    assign trip_set.oc1 = enable.oc1 && oc1_over;
    assign trip_set.oc2 = texp[T_OC2];
    assign trip_set.ns1 = texp[T_NS1];
    assign trip_set.ns2 = texp[T_NS2];
    assign fault_clear = fault_reset || (wr && addr == OFS_FAULT_RESET);
    // A new trip in the reset cycle survives it
    assign next_trip = trip_set | (fault_clear ? '0 : trip);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            trip <= '0;
        else
            trip <= next_trip;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            shutdown <= 1'b0;
            failure_report <= 1'b0;
        end
        else
        begin
            shutdown <= |next_trip;
            failure_report <= next_trip.start_timeout;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    trip_t new_trip;
    trip_t irq_clear;

    assign new_trip = trip_set & ~trip;
    assign irq_clear = (wr && addr == OFS_IRQ_CLEAR)
        ? trip_t'(wdata[4:0]) : '0;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            irq_status <= '0;
        else
            irq_status <= new_trip | (irq_status & ~irq_clear);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |((new_trip | (irq_status & ~irq_clear)) & irq_enable);
    end

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb
    begin
        next_rdata = '0;
        case (addr)
            OFS_ENABLE: next_rdata[4:0] = enable;
            OFS_START_TIMEOUT: next_rdata[DELAY_W-1:0] = start_timeout;
            OFS_OC1_LEVEL: next_rdata[LEVEL_W-1:0] = oc1_level;
            OFS_OC2_LEVEL: next_rdata[LEVEL_W-1:0] = oc2_level;
            OFS_OC2_DELAY: next_rdata[DELAY_W-1:0] = oc2_delay;
            OFS_NS1_LEVEL: next_rdata[LEVEL_W-1:0] = ns1_level;
            OFS_NS1_DELAY: next_rdata[DELAY_W-1:0] = ns1_delay;
            OFS_NS2_LEVEL: next_rdata[LEVEL_W-1:0] = ns2_level;
            OFS_NS2_DELAY: next_rdata[DELAY_W-1:0] = ns2_delay;
            OFS_TRIP_STATUS: next_rdata[4:0] = trip;
            OFS_IRQ_STATUS: next_rdata[4:0] = irq_status;
            OFS_IRQ_ENABLE: next_rdata[4:0] = irq_enable;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rdata <= '0;
        else if (rd)
            rdata <= next_rdata;
        else
            rdata <= '0;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_start_trip;
        enable.start_timeout && starting
            && tcount[T_START] > start_timeout |=> trip.start_timeout;
    endproperty
    a_start_trip: assert property (p_start_trip)
        else $error("start timeout did not trip");

    property p_start_shutdown;
        $rose(trip.start_timeout) |-> shutdown && failure_report;
    endproperty
    a_start_shutdown: assert property (p_start_shutdown)
        else $error("start timeout without failure shutdown");

    property p_disabled_quiet;
        $rose(trip.oc1) |-> $past(enable.oc1);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled overcurrent stage one tripped");

    property p_oc1_now;
        enable.oc1 && (op_state == running) && meas.ia > oc1_level
            |=> trip.oc1;
    endproperty
    a_oc1_now: assert property (p_oc1_now)
        else $error("overcurrent stage one trip was late");

    property p_oc1_double;
        op_state == direct_start && tcount[T_START] <= start_timeout
            |-> oc1_limit == {oc1_level, 1'b0};
    endproperty
    a_oc1_double: assert property (p_oc1_double)
        else $error("direct start level not doubled");

    property p_oc2_states;
        $rose(trip.oc2) |-> $past(quiet_state) && $past(enable.oc2);
    endproperty
    a_oc2_states: assert property (p_oc2_states)
        else $error("overcurrent stage two tripped in a blocked state");

    property p_oc2_release;
        !oc2_over |=> tcount[T_OC2] == 6'h00 ##1 !$rose(trip.oc2);
    endproperty
    a_oc2_release: assert property (p_oc2_release)
        else $error("overcurrent stage two did not release");

    property p_ns1_quad;
        op_state == soft_stop |-> ns1_limit == {ns1_level, 2'b00};
    endproperty
    a_ns1_quad: assert property (p_ns1_quad)
        else $error("negative-sequence level not raised in soft stop");

    property p_ns1_delay;
        $rose(trip.ns1) |-> $past(tcount[T_NS1]) > $past(ns1_delay);
    endproperty
    a_ns1_delay: assert property (p_ns1_delay)
        else $error("negative-sequence stage one tripped early");

    property p_ns2_blocked;
        starting || op_state == soft_stop |=> tcount[T_NS2] == 6'h00;
    endproperty
    a_ns2_blocked: assert property (p_ns2_blocked)
        else $error("negative-sequence stage two counted while blocked");

    property p_latched;
        trip.oc1 && !fault_clear |=> trip.oc1 [*2] or fault_clear ##1 1'b1;
    endproperty
    a_latched: assert property (p_latched)
        else $error("trip dropped without a fault reset");

    c_oc1: cover property (enable.oc1 ##1 $rose(trip.oc1));
    c_start: cover property ($rose(trip.start_timeout));
    c_ns2: cover property ($rose(trip.ns2) ##[1:20] fault_clear);
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ==== verification/motor_side.sv ====
// Purpose: stand-in for current measurement and shutdown control
// Assumes: the bench calls its tasks; values change just after an edge
// Notes: currents are percent of rated current, ten bits per channel
`timescale 1ns/1ps
`default_nettype none
module motor_side
(
    input wire logic clock,
    input wire logic shutdown,
    output protect_pkg::op_state_t op_state,
    output protect_pkg::currents_t meas,
    output logic fault_reset
);
    import protect_pkg::*;

    int shutdowns = 0;

    initial
    begin
        op_state = standby;
        meas = '0;
        fault_reset = 1'b0;
    end

    // The shutdown control acts on every rising request
    always @(posedge shutdown)
        shutdowns++;

    task automatic apply(input op_state_t st, input int a, input int b,
                         input int c, input int n);
        @(posedge clock);
        op_state <= st;
        meas <= '{a[LEVEL_W-1:0], b[LEVEL_W-1:0], c[LEVEL_W-1:0],
                  n[LEVEL_W-1:0]};
    endtask

    // Only an explicit pulse releases latched trips
    task automatic clear_faults();
        @(posedge clock);
        fault_reset <= 1'b1;
        @(posedge clock);
        fault_reset <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: self-checking bench of the current supervisor
// Assumes: one second is shortened to TICK clock cycles
// Notes: delayed trips are accepted from two cycles before delay seconds to 2*TICK+4 cycles after that
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import protect_pkg::*;

    localparam int TICK = 20;
    localparam int OC1_LVL = 450;

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] got;
    trip_t trip;
    op_state_t op_state;
    currents_t meas;
    logic fault_reset;
    logic shutdown;
    logic failure_report;
    logic irq;
    int n_fail = 0;
    int checked = 0;
    int n_shut;
    int en_mask = 31;
    int rst_vals[$] = '{31, 50, 450, 120, 3, 50, 1, 15, 10, 0, 0, 0, 0};

    always #25 clock = ~clock;

    current_supervisor #(.TICK_CYCLES(TICK)) current_supervisor_inst (
        .clock(clock), .rst(rst), .op_state(op_state), .meas(meas),
        .fault_reset(fault_reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .trip(trip), .shutdown(shutdown),
        .failure_report(failure_report), .irq(irq));

    motor_side motor_side_inst (
        .clock(clock), .shutdown(shutdown), .op_state(op_state),
        .meas(meas), .fault_reset(fault_reset));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic reg_wr(input logic [5:0] a, input int d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic idle_and_clear();
        motor_side_inst.apply(standby, 0, 0, 0, 0);
        motor_side_inst.clear_faults();
        wait_cyc(2);
        check({27'h0, trip}, 32'h0);
    endtask

    // Instant stage: the level doubles only in a direct start
    task automatic oc1_case(input op_state_t st, input int v, input int p);
        logic hit;
        hit = v > (st == direct_start ? 2 * OC1_LVL : OC1_LVL);
        hit = hit & en_mask[1];
        motor_side_inst.apply(st, p == 0 ? v : 0, p == 1 ? v : 0,
                              p == 2 ? v : 0, 0);
        wait_cyc(2);
        check({27'h0, trip}, {30'h0, hit, 1'b0});
        idle_and_clear();
    endtask

    // Delayed stage: silent for d seconds less two cycles, then tripped within 2*TICK+4 more cycles
    task automatic delayed(input op_state_t st, input int a, input int n,
                           input int b, input int d, input logic hit);
        int k;
        logic [4:0] e;
        k = 0;
        // b is the mask of every trip that the rules expect to latch when hit is set
        e = hit ? 5'(b) : 5'h00;
        motor_side_inst.apply(st, a, 0, 0, n);
        wait_cyc(d * TICK - 2);
        check({27'h0, trip}, 32'h0);
        while (trip === 5'h00 && k < 2 * TICK + 4)
        begin
            wait_cyc(1);
            k++;
        end
        check({25'h0, failure_report, shutdown, trip},
              {25'h0, e[0], |e, e});
        motor_side_inst.apply(standby, 0, 0, 0, 0);
        wait_cyc(3);
        check({27'h0, trip}, {27'h0, e});
        idle_and_clear();
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h821287b7));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        foreach (rst_vals[i])
        begin
            reg_rd(6'(i * 4), got);
            check(got, rst_vals[i]);
        end
        reg_rd(6'h3c, got);
        check(got, 32'h0);
        reg_wr(OFS_TRIP_STATUS, 31);
        reg_rd(OFS_TRIP_STATUS, got);
        check(got, 32'h0);
        for (int s = 0; s < 6; s++)
            oc1_case(op_state_t'(s), 451 + $urandom % 40, s % 3);
        oc1_case(running, OC1_LVL, 1);
        oc1_case(direct_start, 2 * OC1_LVL + 1, 2);
        en_mask = 29;
        reg_wr(OFS_ENABLE, en_mask);
        oc1_case(running, 480, 0);
        en_mask = 31;
        reg_wr(OFS_ENABLE, en_mask);
        reg_wr(OFS_OC2_DELAY, 2);
        reg_wr(OFS_NS2_DELAY, 1);
        reg_wr(OFS_START_TIMEOUT, 20);
        delayed(running, 121 + $urandom % 100, 0, 5'h04, 2, 1'b1);
        delayed(soft_start, 200, 0, 5'h04, 2, 1'b0);
        delayed(soft_start, 0, 199, 5'h08, 1, 1'b0);
        delayed(soft_stop, 0, 201, 5'h08, 1, 1'b1);
        // Stage two sees the same excess with the same delay in running
        delayed(running, 0, 51, 5'h18, 1, 1'b1);
        delayed(ready, 0, 16, 5'h10, 1, 1'b1);
        delayed(soft_start, 0, 100, 5'h10, 1, 1'b0);
        n_shut = motor_side_inst.shutdowns;
        delayed(soft_start, 0, 0, 5'h01, 20, 1'b1);
        check(motor_side_inst.shutdowns - n_shut, 1);
        reg_wr(OFS_ENABLE, 27);
        delayed(running, 130, 0, 5'h04, 2, 1'b0);
        reg_wr(OFS_ENABLE, 31);
        motor_side_inst.apply(running, 130, 0, 0, 0);
        wait_cyc(30);
        motor_side_inst.apply(running, 0, 0, 0, 0);
        wait_cyc(2);
        motor_side_inst.apply(running, 130, 0, 0, 0);
        wait_cyc(30);
        check({27'h0, trip}, 32'h0);
        wait_cyc(34);
        check({27'h0, trip}, 32'h4);
        idle_and_clear();
        // Status bits are sticky: drop those left by the earlier trips
        reg_wr(OFS_IRQ_CLEAR, 31);
        motor_side_inst.apply(running, 480, 0, 0, 0);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0);
        reg_rd(OFS_IRQ_STATUS, got);
        check(got, 32'h2);
        reg_wr(OFS_IRQ_ENABLE, 2);
        wait_cyc(2);
        check({31'h0, irq}, 32'h1);
        reg_wr(OFS_IRQ_CLEAR, 2);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0);
        reg_rd(OFS_TRIP_STATUS, got);
        check(got, 32'h2);
        motor_side_inst.apply(standby, 0, 0, 0, 0);
        reg_wr(OFS_FAULT_RESET, 1);
        wait_cyc(2);
        check({27'h0, trip}, 32'h0);
        print_verdict();
    end

    initial
    begin
        #(50 * 20000);
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
